//--- hw/lsh_homing_ctl.sv
/*
 * lsh_homing_ctl: limit-switch supervision, border stops, misassignment alarm,
 * two-phase homing with signed standoff, zero and target moves, Avalon-MM slave.
 * assumes one clock, switch pins asynchronous, motor driver takes step/dir.
 */
// Implementation choices: the Avalon-MM register port and the register addresses.
// Functional notes
// - halt when enabled border switch fires
// - detect wrong-border switch, halt on either
// - optional alarm state until cleared
// - configurable pushed level per switch
// - each switch assignable left or right
// - range bounded by positions or switches
// - homing phase one: direction, speed, stop
// - signed standoff move after homing stop
// - go-home runs whole sequence unattended
// - zero command sets position to origin
`timescale 1ns/1ps
module lsh_homing_ctl (
	input wire logic clock_i,         // 50 MHz system clock
	input wire logic sys_rst_i,       // async reset, high
	input wire logic ce_i,            // clock enable, freezes all state
	input wire logic [7:0] avs_address, // byte address
	input wire logic avs_read,        // read request
	input wire logic avs_write,       // write request
	input wire logic [31:0] avs_writedata, // write data
	input wire logic [3:0] avs_byteenable, // byte lanes
	output logic [31:0] avs_readdata, // read data
	output logic avs_waitrequest,     // stall
	input wire logic sw1_pin_i,       // limit switch 1
	input wire logic sw2_pin_i,       // limit switch 2
	input wire logic home_pin_i,      // home sensor
	output logic step_o,              // step pulse to driver
	output logic dir_o,               // 1 = right
	output logic alarm_o,             // alarm state
	output logic irq_o                // level interrupt
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_MOVE,
		ST_HOME1,
		ST_HOME2,
		ST_STANDOFF,
		ST_ALARM
	} lsh_state_t;

	lsh_state_t state;
	lsh_pkg::lsh_ctrl_t ctrl;
	lsh_pkg::lsh_sw_t sw;
	logic [31:0] pos;
	logic [31:0] target;
	logic [31:0] lbord;
	logic [31:0] rbord;
	logic [31:0] wper;
	logic [31:0] h1per;
	logic [31:0] h2per;
	logic [31:0] standoff;
	logic [lsh_pkg::IRQ_W-1:0] irq_stat;
	logic [lsh_pkg::IRQ_W-1:0] irq_mask;
	logic [lsh_pkg::IRQ_W-1:0] ev;
	logic ack;
	logic wr_acc;
	logic rd_acc;
	logic [4:0] cmd;
	logic moving;
	logic run;
	logic step_pulse;
	logic [31:0] period;
	logic blocked;
	logic misset;
	logic phase_hit;
	logic [31:0] so_target;
	logic so_load;

	// ************************************************************
	// helpers
	// ************************************************************
	// byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// signed compare a <= b
	function automatic logic sle(input logic [31:0] a, input logic [31:0] b);
		return $signed(a) <= $signed(b);
	endfunction : sle

	// ************************************************************
	// submodules
	// ************************************************************
	lsh_sw_cond u_sw (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.sw1_pin_i(sw1_pin_i),
		.sw2_pin_i(sw2_pin_i),
		.home_pin_i(home_pin_i),
		.ctrl_i(ctrl),
		.sw_o(sw)
	);

	lsh_step_gen #(.W(32)) u_step (
		.clock_i(clock_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.run_i(run),
		.period_i(period),
		.step_o(step_pulse)
	);

	// ************************************************************
	// bus handshake: one wait cycle, answer on the second edge
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack <= 1'b0;
		end else if (ce_i) begin
			ack <= (avs_read | avs_write) & ~ack;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign wr_acc = avs_write & ack & ce_i;
	assign rd_acc = avs_read & ~ack & ce_i;
	assign cmd = (wr_acc && avs_address == lsh_pkg::REG_CMD && avs_byteenable[0]) ? avs_writedata[4:0] : 5'h00;

	// read data latched one cycle ahead of the accepting edge
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			avs_readdata <= 32'h0000_0000;
		end else if (rd_acc) begin
			case (avs_address)
				lsh_pkg::REG_CTRL: avs_readdata <= {18'h00000, ctrl};
				lsh_pkg::REG_STAT: avs_readdata <= {20'h00000, sw, dir_o, moving, alarm_o, 1'b0, state};
				lsh_pkg::REG_POS: avs_readdata <= pos;
				lsh_pkg::REG_TARGET: avs_readdata <= target;
				lsh_pkg::REG_LBORD: avs_readdata <= lbord;
				lsh_pkg::REG_RBORD: avs_readdata <= rbord;
				lsh_pkg::REG_WPER: avs_readdata <= wper;
				lsh_pkg::REG_H1PER: avs_readdata <= h1per;
				lsh_pkg::REG_H2PER: avs_readdata <= h2per;
				lsh_pkg::REG_STANDOFF: avs_readdata <= standoff;
				lsh_pkg::REG_IRQ_STAT: avs_readdata <= {27'h0000000, irq_stat};
				lsh_pkg::REG_IRQ_MASK: avs_readdata <= {27'h0000000, irq_mask};
				default: avs_readdata <= 32'h0000_0000; // unmapped and CMD read zero
			endcase
		end
	end

	// ************************************************************
	// configuration registers
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctrl <= lsh_pkg::lsh_ctrl_t'(lsh_pkg::CTRL_RST);
			target <= 32'h0000_0000;
			lbord <= lsh_pkg::LBORD_RST;
			rbord <= lsh_pkg::RBORD_RST;
			wper <= lsh_pkg::WPER_RST;
			h1per <= lsh_pkg::H1PER_RST;
			h2per <= lsh_pkg::H2PER_RST;
			standoff <= 32'h0000_0000;
			irq_mask <= '0;
		end else if (wr_acc) begin
			case (avs_address)
				lsh_pkg::REG_CTRL: ctrl <= lsh_pkg::lsh_ctrl_t'(14'(merge({18'h00000, ctrl}, avs_writedata,
					avs_byteenable)));
				lsh_pkg::REG_TARGET: target <= merge(target, avs_writedata, avs_byteenable);
				lsh_pkg::REG_LBORD: lbord <= merge(lbord, avs_writedata, avs_byteenable);
				lsh_pkg::REG_RBORD: rbord <= merge(rbord, avs_writedata, avs_byteenable);
				lsh_pkg::REG_WPER: wper <= merge(wper, avs_writedata, avs_byteenable);
				lsh_pkg::REG_H1PER: h1per <= merge(h1per, avs_writedata, avs_byteenable);
				lsh_pkg::REG_H2PER: h2per <= merge(h2per, avs_writedata, avs_byteenable);
				lsh_pkg::REG_STANDOFF: standoff <= merge(standoff, avs_writedata, avs_byteenable);
				lsh_pkg::REG_IRQ_MASK: irq_mask <= avs_writedata[lsh_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ************************************************************
	// supervision terms
	// ************************************************************
	assign moving = (state == ST_MOVE) || (state == ST_HOME1) || (state == ST_HOME2) || (state == ST_STANDOFF);

	// a switch of the wrong border while heading the other way means the
	// wiring is swapped; it only helps at setup, it cannot undo a jam
	assign misset = ctrl.misset_det && moving && ((dir_o && sw.left) || (!dir_o && sw.right));

	// border block in the current direction, by switches or by positions
	always_comb begin
		blocked = 1'b0;
		if (ctrl.border_by_sw) begin
			blocked = (dir_o && ctrl.stop_right && sw.right) || (!dir_o && ctrl.stop_left && sw.left);
		end else begin
			blocked = (dir_o && ctrl.stop_right && sle(rbord, pos)) || (!dir_o && ctrl.stop_left && sle(pos, lbord));
		end
		// with detection on, either switch halts motion
		if (ctrl.misset_det && (sw.sw1 || sw.sw2) && moving) begin
			blocked = 1'b1;
		end
	end

	// homing stop condition: switch of travel direction or home sensor
	always_comb begin
		phase_hit = 1'b0;
		if (state == ST_HOME1) begin
			phase_hit = ctrl.stop1_sw ? (ctrl.dir1_right ? sw.right : sw.left) : sw.home;
		end else if (state == ST_HOME2) begin
			phase_hit = ctrl.stop2_sw ? (ctrl.dir2_right ? sw.right : sw.left) : sw.home;
		end
	end

	// speed per phase; targeted moves stop on the step that lands on target
	always_comb begin
		case (state)
			ST_HOME1: period = h1per;
			ST_HOME2: period = h2per;
			default: period = wper;
		endcase
	end

	assign run = moving && !blocked && !phase_hit && !misset && !cmd[lsh_pkg::CMD_STOP]
		&& !((state == ST_MOVE && pos == target) || (state == ST_STANDOFF && pos == so_target));

	// ************************************************************
	// motion state machine
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			dir_o <= 1'b0;
			alarm_o <= 1'b0;
			ev <= '0;
		end else if (ce_i) begin
			ev <= '0;
			case (state)
				ST_IDLE: begin
					if (cmd[lsh_pkg::CMD_HOME]) begin
						state <= ST_HOME1;
						dir_o <= ctrl.dir1_right;
					end else if (cmd[lsh_pkg::CMD_MOVE] && target != pos) begin
						state <= ST_MOVE;
						dir_o <= sle(pos, target);
					end
				end
				ST_ALARM: begin
					// no motion until software clears the alarm
					if (cmd[lsh_pkg::CMD_CLR_ALARM]) begin
						state <= ST_IDLE;
						alarm_o <= 1'b0;
					end
				end
				default: begin
					if (misset && ctrl.alarm_on_misset) begin
						state <= ST_ALARM;
						alarm_o <= 1'b1;
						ev[lsh_pkg::EV_MISSET] <= 1'b1;
						ev[lsh_pkg::EV_ALARM] <= 1'b1;
					end else if (misset) begin
						state <= ST_IDLE;
						ev[lsh_pkg::EV_MISSET] <= 1'b1;
					end else if (cmd[lsh_pkg::CMD_STOP]) begin
						state <= ST_IDLE;
					end else if (state == ST_HOME1 && phase_hit) begin
						// reaching the home stop is the goal, not a border fault
						if (ctrl.use_phase2) begin
							state <= ST_HOME2;
							dir_o <= ctrl.dir2_right;
						end else begin
							state <= ST_STANDOFF;
							dir_o <= ~standoff[31];
						end
					end else if (state == ST_HOME2 && phase_hit) begin
						state <= ST_STANDOFF;
						dir_o <= ~standoff[31];
					end else if (blocked) begin
						state <= ST_IDLE;
						ev[lsh_pkg::EV_BORDER] <= 1'b1;
					end else if ((state == ST_MOVE && pos == target) || (state == ST_STANDOFF && pos == so_target)) begin
						state <= ST_IDLE;
						ev[lsh_pkg::EV_MOVE_DONE] <= (state == ST_MOVE);
						ev[lsh_pkg::EV_HOME_DONE] <= (state == ST_STANDOFF);
					end
				end
			endcase
		end
	end

	// ************************************************************
	// position counter, standoff target and step output
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pos <= 32'h0000_0000;
			step_o <= 1'b0;
		end else if (ce_i) begin
			step_o <= step_pulse & run; // a step queued before a stop is dropped
			if (cmd[lsh_pkg::CMD_ZERO]) begin
				pos <= 32'h0000_0000;
			end else if (step_pulse && run) begin
				pos <= dir_o ? pos + 32'h0000_0001 : pos - 32'h0000_0001;
			end
		end
	end

	// standoff target is taken from the stop point, signed, positive right
	assign so_load = (state == ST_HOME1 && phase_hit && !ctrl.use_phase2) || (state == ST_HOME2 && phase_hit);
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			so_target <= 32'h0000_0000;
		end else if (ce_i && so_load && !misset) begin
			so_target <= pos + standoff;
		end
	end

	// ************************************************************
	// interrupt status: set wins over write-one-to-clear
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_stat <= '0;
		end else if (ce_i) begin
			if (wr_acc && avs_address == lsh_pkg::REG_IRQ_STAT) begin
				irq_stat <= (irq_stat & ~avs_writedata[lsh_pkg::IRQ_W-1:0]) | ev;
			end else begin
				irq_stat <= irq_stat | ev;
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);
endmodule : lsh_homing_ctl

//--- hw/lsh_pkg.sv
/*
 * lsh_pkg: register map, field positions, command codes and shared types of the
 * limit-switch supervision and homing block.
 * assumes a 32-bit Avalon-MM slave port with byte addresses on word boundaries.
 */
package lsh_pkg;
	// ************************************************************
	// register byte offsets
	// ************************************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	localparam logic [7:0] REG_POS = 8'h0c;
	localparam logic [7:0] REG_TARGET = 8'h10;
	localparam logic [7:0] REG_LBORD = 8'h14;
	localparam logic [7:0] REG_RBORD = 8'h18;
	localparam logic [7:0] REG_WPER = 8'h1c;
	localparam logic [7:0] REG_H1PER = 8'h20;
	localparam logic [7:0] REG_H2PER = 8'h24;
	localparam logic [7:0] REG_STANDOFF = 8'h28;
	localparam logic [7:0] REG_IRQ_STAT = 8'h2c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h30;

	// ************************************************************
	// command bits (write-only pulses)
	// ************************************************************
	localparam int CMD_MOVE = 0;
	localparam int CMD_HOME = 1;
	localparam int CMD_ZERO = 2;
	localparam int CMD_STOP = 3;
	localparam int CMD_CLR_ALARM = 4;

	// ************************************************************
	// interrupt event bits
	// ************************************************************
	localparam int IRQ_W = 5;
	localparam int EV_MOVE_DONE = 0;
	localparam int EV_HOME_DONE = 1;
	localparam int EV_BORDER = 2;
	localparam int EV_MISSET = 3;
	localparam int EV_ALARM = 4;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [13:0] CTRL_RST = 14'h0007;
	localparam logic [31:0] WPER_RST = 32'h0000_c350;
	localparam logic [31:0] H1PER_RST = 32'h0007_a120;
	localparam logic [31:0] H2PER_RST = 32'h0026_25a0;
	localparam logic [31:0] LBORD_RST = 32'h8000_0000;
	localparam logic [31:0] RBORD_RST = 32'h7fff_ffff;

	// control register layout, bit 13 first
	typedef struct packed {
		logic stop2_sw;      // 13: phase 2 stops on switch, else home sensor
		logic stop1_sw;      // 12: phase 1 stops on switch, else home sensor
		logic dir2_right;    // 11
		logic use_phase2;    // 10
		logic dir1_right;    // 9
		logic border_by_sw;  // 8: 1 switches bound range, 0 positions
		logic sw2_right;     // 7
		logic sw1_right;     // 6
		logic sw2_open;      // 5: 1 active when open (input low)
		logic sw1_open;      // 4
		logic alarm_on_misset; // 3
		logic misset_det;    // 2
		logic stop_right;    // 1
		logic stop_left;     // 0
	} lsh_ctrl_t;

	// conditioned switch view
	typedef struct packed {
		logic sw1;    // switch 1 pushed
		logic sw2;    // switch 2 pushed
		logic left;   // a switch assigned left is pushed
		logic right;  // a switch assigned right is pushed
		logic home;   // home sensor active
	} lsh_sw_t;
endpackage : lsh_pkg

//--- hw/lsh_sw_cond.sv
/*
 * lsh_sw_cond: synchronises the two limit-switch pins and the home sensor,
 * applies the pushed level and maps each switch to a border.
 * assumes raw pins asynchronous to clock_i; freezes while ce_i is low.
 */
`timescale 1ns/1ps
module lsh_sw_cond (
	input wire logic clock_i,            // system clock
	input wire logic sys_rst_i,          // async reset, high
	input wire logic ce_i,               // clock enable
	input wire logic sw1_pin_i,          // limit switch 1 pin
	input wire logic sw2_pin_i,          // limit switch 2 pin
	input wire logic home_pin_i,         // home sensor pin
	input wire lsh_pkg::lsh_ctrl_t ctrl_i, // configuration
	output lsh_pkg::lsh_sw_t sw_o        // conditioned view
);
	logic [2:0] meta;
	logic [2:0] sync;
	logic a1;
	logic a2;

	// ************************************************************
	// two-stage synchroniser; meta is read by sync only
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meta <= 3'h0;
			sync <= 3'h0;
		end else if (ce_i) begin
			meta <= {home_pin_i, sw2_pin_i, sw1_pin_i};
			sync <= meta;
		end
	end

	// pushed level per switch, so an idle switch reads inactive
	assign a1 = sync[0] ^ ctrl_i.sw1_open;
	assign a2 = sync[1] ^ ctrl_i.sw2_open;

	// border mapping
	always_comb begin
		sw_o.sw1 = a1;
		sw_o.sw2 = a2;
		sw_o.left = (a1 & ~ctrl_i.sw1_right) | (a2 & ~ctrl_i.sw2_right);
		sw_o.right = (a1 & ctrl_i.sw1_right) | (a2 & ctrl_i.sw2_right);
		sw_o.home = sync[2];
	end
endmodule : lsh_sw_cond

//--- hw/lsh_step_gen.sv
/*
 * lsh_step_gen: emits one-cycle step pulses at a programmed period.
 * assumes period in clock cycles; period 0 behaves as 1.
 */
`timescale 1ns/1ps
module lsh_step_gen #(
	parameter int W = 32 // period width
) (
	input wire logic clock_i,        // system clock
	input wire logic sys_rst_i,      // async reset, high
	input wire logic ce_i,           // clock enable
	input wire logic run_i,          // generate steps
	input wire logic [W-1:0] period_i, // cycles per step
	output logic step_o              // one-cycle step pulse
);
	logic [W-1:0] cnt;

	// period counter; restarts whenever motion stops so first step is a full period
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
			step_o <= 1'b0;
		end else if (ce_i) begin
			step_o <= 1'b0;
			if (!run_i) begin
				cnt <= '0;
			end else if (cnt + W'(1) >= period_i) begin
				cnt <= '0;
				step_o <= 1'b1;
			end else begin
				cnt <= cnt + W'(1);
			end
		end
	end
endmodule : lsh_step_gen

//--- testbench/lsh_homing_chk.sv
/* lsh_homing_chk: port assertions for the homing block (bus, border stops, alarm).
   assumes control writes use all byte lanes and one clock domain. */
`timescale 1ns/1ps
module lsh_homing_chk (
	input wire logic clock_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic ce_i, // enable
	input wire logic [7:0] avs_address, // address
	input wire logic avs_read, // read
	input wire logic avs_write, // write
	input wire logic [31:0] avs_writedata, // data
	input wire logic avs_waitrequest, // stall
	input wire logic sw1_pin_i, // switch 1
	input wire logic sw2_pin_i, // switch 2
	input wire logic step_o, // step
	input wire logic dir_o, // direction
	input wire logic alarm_o, // alarm
	input wire logic irq_o // interrupt
);
	// ************************************************************
	// shadow of control and pin meaning
	// ************************************************************
	lsh_pkg::lsh_ctrl_t c;
	logic req, p1, p2, lp, rp, stl, str, clr;
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	// copy of control so that pin levels can be read as pushed
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) c <= lsh_pkg::CTRL_RST;
		else if (ce_i && avs_write && !avs_waitrequest && avs_address == lsh_pkg::REG_CTRL) c <= avs_writedata[13:0];
	end
	// misset detection halts on any switch, so it counts as a stop too
	assign req = avs_read | avs_write;
	assign p1 = sw1_pin_i ^ c.sw1_open;
	assign p2 = sw2_pin_i ^ c.sw2_open;
	assign lp = (p1 & ~c.sw1_right) | (p2 & ~c.sw2_right);
	assign rp = (p1 & c.sw1_right) | (p2 & c.sw2_right);
	assign stl = (c.border_by_sw & c.stop_left) | c.misset_det;
	assign str = (c.border_by_sw & c.stop_right) | c.misset_det;
	assign clr = avs_write & ~avs_waitrequest & (avs_address == lsh_pkg::REG_CMD) & avs_writedata[4];
	// six cycles cover the two-stage sync plus the registered step
	sequence s_left; (stl & lp & ~dir_o) [*6]; endsequence
	sequence s_right; (str & rp & dir_o) [*6]; endsequence
	property p_stop_left; s_left |-> !step_o; endproperty
	property p_stop_right; s_right |-> !step_o; endproperty
	property p_wait_one; (req & avs_waitrequest & ce_i) |=> !avs_waitrequest; endproperty
	property p_wait_again; (req & !avs_waitrequest) ##1 req |-> avs_waitrequest; endproperty
	property p_idle_bus; !req |-> !avs_waitrequest; endproperty
	property p_rst_out; $fell(sys_rst_i) |-> !(alarm_o | irq_o | step_o); endproperty
	property p_alarm_still; alarm_o && $past(alarm_o) |-> !step_o; endproperty
	property p_alarm_keep; alarm_o && !clr |=> alarm_o; endproperty
	a_stop_left: assert property (p_stop_left) else $error("step toward a pushed left switch");
	a_stop_right: assert property (p_stop_right) else $error("step toward a pushed right switch");
	a_wait_one: assert property (p_wait_one) else $error("bus wait longer than one cycle");
	a_wait_again: assert property (p_wait_again) else $error("held request got no wait cycle");
	a_idle_bus: assert property (p_idle_bus) else $error("waitrequest high while idle");
	a_rst_out: assert property (p_rst_out) else $error("output high after reset");
	a_alarm_still: assert property (p_alarm_still) else $error("step while in alarm");
	a_alarm_keep: assert property (p_alarm_keep) else $error("alarm left without clear");
endmodule : lsh_homing_chk
bind lsh_homing_ctl lsh_homing_chk u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .sw1_pin_i(sw1_pin_i), .sw2_pin_i(sw2_pin_i), .step_o(step_o),
	.dir_o(dir_o), .alarm_o(alarm_o), .irq_o(irq_o));

//--- testbench/lsh_stage_model.sv
/* lsh_stage_model: stage with switch 1 at the left end, switch 2 at the right, a home mark.
   assumes one-cycle step pulses; pin level is pushed XOR the open input. */
`timescale 1ns/1ps
module lsh_stage_model #(
	parameter int LEFT_POS = -20, // switch 1 pushed at or below
	parameter int RIGHT_POS = 30, // switch 2 pushed at or above
	parameter int HOME_POS = -12 // home mark position
) (
	input wire logic clock_i, // clock
	input wire logic sys_rst_i, // reset
	input wire logic step_i, // step pulse
	input wire logic dir_i, // 1 right
	input wire logic open1_i, // switch 1 opens when pushed
	input wire logic open2_i, // switch 2 opens when pushed
	output logic sw1_pin_o, // switch 1 pin
	output logic sw2_pin_o, // switch 2 pin
	output logic home_pin_o, // home pin
	output int pos_o // stage position
);
	// ************************************************************
	// mechanics
	// ************************************************************
	// one step per pulse, right counts up
	always_ff @(posedge clock_i or posedge sys_rst_i) begin
		if (sys_rst_i) pos_o <= 0;
		else if (step_i) pos_o <= dir_i ? pos_o + 1 : pos_o - 1;
	end
	// switches stay pushed past the end, so an overshoot is not hidden
	assign sw1_pin_o = (pos_o <= LEFT_POS) ^ open1_i;
	assign sw2_pin_o = (pos_o >= RIGHT_POS) ^ open2_i;
	assign home_pin_o = pos_o == HOME_POS;
endmodule : lsh_stage_model

//--- testbench/tb_limit_switch_homing_control.sv
/* tb_limit_switch_homing_control: register-driven runs of the homing block against a stage.
   assumes the package map, one wait cycle per access and stage start at position 0. */
`timescale 1ns/1ps
module tb_limit_switch_homing_control;
	logic clock_i = 0, sys_rst_i = 1, avs_read = 0, avs_write = 0, opn = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rd, q;
	logic wt, step, dir, alarm, irq, s1, s2, hm;
	int pos, num_checks = 0, n_errors = 0, cyc = 0, org = 0, t;
	integer seed = 32'he4e9f5ae;
	int hc[3] = '{32'h1383, 32'h1d83, 32'h1d83};
	int hso[3] = '{-4, 3, 3};
	int hend[3] = '{26, -9, -9};
	logic [7:0] ra[6] = '{lsh_pkg::REG_CTRL, lsh_pkg::REG_WPER, lsh_pkg::REG_H1PER,
		lsh_pkg::REG_H2PER, lsh_pkg::REG_RBORD, 8'h3c};
	logic [31:0] rv[6] = '{32'h7, lsh_pkg::WPER_RST, lsh_pkg::H1PER_RST, lsh_pkg::H2PER_RST,
		lsh_pkg::RBORD_RST, 32'h0};
	// ************************************************************
	// block, stage and clock
	// ************************************************************
	lsh_homing_ctl dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .avs_address(adr),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wd), .avs_byteenable(4'hf),
		.avs_readdata(rd), .avs_waitrequest(wt), .sw1_pin_i(s1), .sw2_pin_i(s2), .home_pin_i(hm),
		.step_o(step), .dir_o(dir), .alarm_o(alarm), .irq_o(irq));
	lsh_stage_model u_stage (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .step_i(step), .dir_i(dir),
		.open1_i(opn), .open2_i(opn), .sw1_pin_o(s1), .sw2_pin_o(s2), .home_pin_o(hm), .pos_o(pos));
	initial forever #10 clock_i = ~clock_i;
	// hang guard, far above the thousand or so cycles the run needs
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// one access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock_i);
		avs_write <= w;
		avs_read <= ~w;
		adr <= a;
		wd <= d;
		do @(posedge clock_i); while (wt !== 1'b0);
		q = rd;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		#1;
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask : rdc
	// polling is bounded; state 0 is idle, 5 is alarm
	task automatic idle();
		for (int n = 0; n < 3000; n++) begin
			bus(1'b0, lsh_pkg::REG_STAT, 32'h0);
			if (q[2:0] == 3'h0 || q[2:0] == 3'h5) break;
		end
	endtask : idle
	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_of_test
	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		repeat (4) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) rdc(ra[i], rv[i], "reset value");
		// short periods keep every run brief
		bus(1'b1, lsh_pkg::REG_WPER, 32'h4);
		bus(1'b1, lsh_pkg::REG_H1PER, 32'h6);
		bus(1'b1, lsh_pkg::REG_H2PER, 32'h8);
		bus(1'b1, lsh_pkg::REG_IRQ_MASK, 32'h1e);
		bus(1'b1, lsh_pkg::REG_CTRL, 32'h187);
		t = ($random(seed) & 32'hf) + 1;
		bus(1'b1, lsh_pkg::REG_TARGET, t);
		bus(1'b1, lsh_pkg::REG_CMD, 32'h1);
		idle();
		chk("idle switches", q[11:7], 5'h0);
		rdc(lsh_pkg::REG_POS, t, "move pos");
		chk("stage", pos, t);
		chk("masked irq", irq, 1'b0);
		bus(1'b1, lsh_pkg::REG_IRQ_MASK, 32'h1f);
		chk("irq", irq, 1'b1);
		bus(1'b1, lsh_pkg::REG_IRQ_STAT, 32'h1f);
		chk("irq clear", irq, 1'b0);
		bus(1'b1, lsh_pkg::REG_CMD, 32'h4);
		org = pos;
		rdc(lsh_pkg::REG_POS, 32'h0, "zero");
		// homing to each switch, with and without a second phase
		for (int i = 0; i < 3; i++) begin
			if (i == 2) begin
				bus(1'b1, lsh_pkg::REG_CMD, 32'h4);
				org = pos;
				bus(1'b1, lsh_pkg::REG_TARGET, 32'hc);
				bus(1'b1, lsh_pkg::REG_CMD, 32'h1);
				idle();
			end
			bus(1'b1, lsh_pkg::REG_CTRL, hc[i]);
			bus(1'b1, lsh_pkg::REG_STANDOFF, hso[i]);
			bus(1'b1, lsh_pkg::REG_CMD, 32'h2);
			idle();
			rdc(lsh_pkg::REG_POS, hend[i] - org, "home pos");
			chk("home stage", pos, hend[i]);
			rdc(lsh_pkg::REG_IRQ_STAT, i == 2 ? 32'h3 : 32'h2, "home event");
			bus(1'b1, lsh_pkg::REG_IRQ_STAT, 32'h1f);
		end
		// range bounded by position instead of switches
		bus(1'b1, lsh_pkg::REG_CTRL, 32'h83);
		bus(1'b1, lsh_pkg::REG_RBORD, 32'h6);
		bus(1'b1, lsh_pkg::REG_TARGET, 32'h28);
		bus(1'b1, lsh_pkg::REG_CMD, 32'h1);
		idle();
		chk("border stage", pos, 6 + org);
		rdc(lsh_pkg::REG_IRQ_STAT, 32'h4, "border event");
		bus(1'b1, lsh_pkg::REG_IRQ_STAT, 32'h1f);
		// switches wired open and assigned the wrong way round
		opn <= 1'b1;
		bus(1'b1, lsh_pkg::REG_CTRL, 32'h17f);
		bus(1'b0, lsh_pkg::REG_STAT, 32'h0);
		chk("open idle", q[11:7], 5'h0);
		bus(1'b1, lsh_pkg::REG_TARGET, -40);
		bus(1'b1, lsh_pkg::REG_CMD, 32'h1);
		idle();
		chk("alarm state", q[2:0], 3'h5);
		chk("alarm", alarm, 1'b1);
		chk("halted", pos > -23, 1'b1);
		bus(1'b0, lsh_pkg::REG_IRQ_STAT, 32'h0);
		chk("alarm event", q[4], 1'b1);
		t = pos;
		bus(1'b1, lsh_pkg::REG_CMD, 32'h1);
		repeat (30) @(posedge clock_i);
		chk("no resume", pos, t);
		bus(1'b1, lsh_pkg::REG_CMD, 32'h10);
		bus(1'b0, lsh_pkg::REG_STAT, 32'h0);
		chk("alarm cleared", alarm, 1'b0);
		// correct mapping while resting on the left switch: a left move must not start
		bus(1'b1, lsh_pkg::REG_CTRL, 32'h1b3);
		bus(1'b1, lsh_pkg::REG_CMD, 32'h1);
		idle();
		chk("held at switch", pos, t);
		rdc(lsh_pkg::REG_IRQ_STAT, 32'h1c, "left stop");
		end_of_test();
	end
endmodule : tb_limit_switch_homing_control
